// ==== pnp_port.sv ====
// Parallel programming port: loading, command decode, erase, writes and reads
`default_nettype none
// Function
// - A fuse bit reads zero when programmed and one when unprogrammed.
// - Upper byte: reset-as-io 4, serial-load 3, keep 2, brownout 1:0, 7:5 read one.
// - Lower byte: pll 7, osc option 6, startup 5:4, clock source 3:0.
// - The serial-load fuse cannot be changed while in serial programming mode.
// - Fuses survive chip erase and refuse writes while lock bit one is programmed.
// - Fuses latch at entry, exit and power-up; keep-data fuse acts at once.
// - Three identification bytes at addresses 0 to 2, readable even when locked.
// - Four trims at addresses 0 to 3; the 1 MHz trim loads at reset.
// - Flash is 64 pages of 16 words; bits 3:0 word, 9:4 page.
// - Data memory is 32 pages of 4 bytes; bits 1:0 pick the byte.
// - Ready flag is low while busy; the bus is driven only while output-drive low.
// - Byte pick one selects low or high byte; pick two selects second high byte.
// - A load-strobe pulse loads address, data or command per the action selects.
// - Registers change only on load strobe; pick two is used only for fuse reads.
// - Command bytes decode to erase, writes and reads as listed.
// - A write or output-drive pulse performs the most recently loaded command.
// - Command and address stay loaded across operations.
// - Erase clears flash, locks and data unless kept; locks release after flash.
// - Erase is command load then write pulse; ready stays low until done.
module pnp_port
    import pnp_pkg::*;
(
    input  wire logic       clk,            // System clock, 50 MHz
    input  wire logic       resetn,         // Asynchronous reset, active low
    input  wire logic [7:0] dataIn,         // Data bus pin, input side
    output logic      [7:0] dataOut,        // Data bus pin, output side
    output logic            dataOe,         // Data bus output enable
    input  wire logic       loadStrobe,     // Load strobe, positive pulse
    input  wire logic       actionSelHi,    // Action select high, also byte pick two
    input  wire logic       actionSelLo,    // Action select low
    input  wire logic       pageLatch,      // Byte pick one, shared with page latch
    input  wire logic       programStrobeN, // Write strobe, active low
    input  wire logic       outputDriveN,   // Output enable, active low
    input  wire logic       progVoltage,    // High voltage seen on reset pin
    input  wire logic       serialMode,     // Serial programming mode active
    output logic            readyFlag,      // High when ready for a command
    output logic            progMode,       // Parallel programming mode active
    output logic      [7:0] fuseUpperEff,   // Latched upper configuration byte, keep bit follows live
    output logic      [7:0] fuseLowerEff,   // Latched lower configuration byte
    output logic      [7:0] oscTrim         // Oscillator trim register
);
    import pnp_pkg::*;

    logic [1:0] rstSync_r;
    logic       rstN;
    pnp_pins_t  pinRaw, pins;
    logic       ldPrev_r, wrPrev_r, hvPrev_r;
    logic       ldRise, wrFall, hvRise, hvFall, accept;
    logic [7:0] cmd_r, cmdNxt, addrLo_r, addrLoNxt, addrHi_r, addrHiNxt;
    logic [7:0] dataLo_r, dataLoNxt;
    logic [7:0] fuUp_r, fuUpNxt, fuLo_r, fuLoNxt, effUp_r, effUpNxt, effLo_r, effLoNxt;
    logic [1:0] lock_r, lockNxt;
    logic       mode_r, modeNxt, pup_r;
    pnp_state_t state_r, stateNxt;
    logic [10:0] walkCnt_r, walkCntNxt, walkTop_r, walkTopNxt;
    logic       erasing_r, erasingNxt, pipeVld_r, pipeVldNxt;
    logic [9:0] pipeIdx_r, pipeIdxNxt;
    logic       bufWe, flWe, eeWe;
    logic [3:0] bufWAddr;
    logic [15:0] bufWData, bufRd, flRd, flWData;
    logic [9:0] flWAddr;
    logic [6:0] eeWAddr;
    logic [7:0] eeRd, eeWData;
    logic [7:0] dOut_r, dOutNxt, trim_r;
    logic       dOe_r, dOeNxt, ready_r;

    // Reset release through two flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rstSync_r <= 2'b00;
        end else begin
            rstSync_r <= {rstSync_r[0], 1'b1};
        end
    end
    assign rstN = rstSync_r[1];

    // Every pin crosses two flops before any logic looks at it
    assign pinRaw = '{ld: loadStrobe, actHi: actionSelHi, actLo: actionSelLo,
        pick1: pageLatch, wrN: programStrobeN, oeN: outputDriveN,
        hv: progVoltage, serial: serialMode, data: dataIn};

    pnp_sync #(.W($bits(pnp_pins_t)), .INIT(PINS_RST)) u_sync (
        .clk  (clk),
        .rstN (rstN),
        .d    (pinRaw),
        .q    (pins)
    );

    // Edge history of the synchronised strobes
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            ldPrev_r <= 1'b0;
            wrPrev_r <= 1'b1;
            hvPrev_r <= 1'b0;
        end else begin
            ldPrev_r <= pins.ld;
            wrPrev_r <= pins.wrN;
            hvPrev_r <= pins.hv;
        end
    end
    assign ldRise = pins.ld & ~ldPrev_r;
    assign wrFall = ~pins.wrN & wrPrev_r;
    assign hvRise = pins.hv & ~hvPrev_r;
    assign hvFall = ~pins.hv & hvPrev_r;
    // Load and write strobes are ignored outside programming mode and while busy
    assign accept = mode_r && (state_r == S_IDLE);

    // Command, address and data loading; values persist until reloaded
    always_comb begin
        cmdNxt    = cmd_r;
        addrLoNxt = addrLo_r;
        addrHiNxt = addrHi_r;
        dataLoNxt = dataLo_r;
        bufWe     = 1'b0;
        bufWData  = {pins.data, dataLo_r};
        bufWAddr  = (cmd_r == CMD_WEE) ? {2'b00, addrLo_r[1:0]} : addrLo_r[3:0];
        if (accept && ldRise) begin
            case (pnp_act_t'({pins.actHi, pins.actLo}))
                ACT_ADDR: begin
                    if (pins.pick1) begin
                        addrHiNxt = pins.data;
                    end else begin
                        addrLoNxt = pins.data;
                    end
                end
                ACT_DATA: begin
                    if (cmd_r == CMD_WEE) begin
                        bufWe    = 1'b1;
                        bufWData = {BUS_IDLE, pins.data};
                    end else if (pins.pick1) begin
                        bufWe = 1'b1;
                    end else begin
                        dataLoNxt = pins.data;
                    end
                end
                ACT_CMD:  cmdNxt = pins.data;
                default:  cmdNxt = cmd_r; // No action
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            cmd_r    <= 8'h00;
            addrLo_r <= 8'h00;
            addrHi_r <= 8'h00;
            dataLo_r <= 8'h00;
        end else begin
            cmd_r    <= cmdNxt;
            addrLo_r <= addrLoNxt;
            addrHi_r <= addrHiNxt;
            dataLo_r <= dataLoNxt;
        end
    end

    // Write sequencer: walks the page buffer or the whole array for erase
    always_comb begin
        stateNxt   = state_r;
        walkCntNxt = walkCnt_r;
        walkTopNxt = walkTop_r;
        erasingNxt = erasing_r;
        pipeVldNxt = 1'b0;
        pipeIdxNxt = walkCnt_r[9:0];
        case (state_r)
            S_IDLE: begin
                walkCntNxt = 11'h000;
                if (accept && wrFall) begin
                    if (cmd_r == CMD_ERASE) begin
                        stateNxt   = S_WALK;
                        walkTopNxt = FL_WORDS;
                        erasingNxt = 1'b1;
                    end else if ((cmd_r == CMD_WFLASH) && lock_r[0]) begin
                        stateNxt   = S_WALK;
                        walkTopNxt = PG_WORDS;
                    end else if ((cmd_r == CMD_WEE) && lock_r[0]) begin
                        stateNxt   = S_WALK;
                        walkTopNxt = EE_PG;
                    end else if ((cmd_r == CMD_WFUSE) || (cmd_r == CMD_WLOCK)) begin
                        stateNxt = S_DONE;
                    end
                end
            end
            S_WALK: begin
                if (walkCnt_r != walkTop_r) begin
                    pipeVldNxt = 1'b1;
                    walkCntNxt = walkCnt_r + 11'h001;
                end else if (!pipeVld_r) begin
                    stateNxt = S_DONE;
                end
            end
            S_DONE: begin
                stateNxt   = S_IDLE;
                erasingNxt = 1'b0;
            end
            default: stateNxt = S_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state_r   <= S_IDLE;
            walkCnt_r <= 11'h000;
            walkTop_r <= 11'h000;
            erasing_r <= 1'b0;
            pipeVld_r <= 1'b0;
            pipeIdx_r <= 10'h000;
        end else begin
            state_r   <= stateNxt;
            walkCnt_r <= walkCntNxt;
            walkTop_r <= walkTopNxt;
            erasing_r <= erasingNxt;
            pipeVld_r <= pipeVldNxt;
            pipeIdx_r <= pipeIdxNxt;
        end
    end

    // Array writes one cycle behind the buffer read; erase writes all ones
    assign flWe    = pipeVld_r && (erasing_r || (cmd_r == CMD_WFLASH));
    assign flWAddr = erasing_r ? pipeIdx_r : {addrHi_r[1:0], addrLo_r[7:4], pipeIdx_r[3:0]};
    assign flWData = erasing_r ? {BUS_IDLE, BUS_IDLE} : bufRd;
    // Keep-data fuse is read live so it acts as soon as it is programmed
    assign eeWe    = pipeVld_r && (erasing_r ? ((pipeIdx_r[9:7] == 3'b000) && fuUp_r[FU_KEEP])
                                             : (cmd_r == CMD_WEE));
    assign eeWAddr = erasing_r ? pipeIdx_r[6:0] : {addrLo_r[6:2], pipeIdx_r[1:0]};
    assign eeWData = erasing_r ? BUS_IDLE : bufRd[7:0];

    pnp_mem #(.DW(16), .AW(BUF_AW)) u_pageBuf (
        .clk   (clk),
        .we    (bufWe),
        .wAddr (bufWAddr),
        .wData (bufWData),
        .rAddr (walkCnt_r[3:0]),
        .rData (bufRd)
    );

    pnp_mem #(.DW(16), .AW(FL_AW)) u_flash (
        .clk   (clk),
        .we    (flWe),
        .wAddr (flWAddr),
        .wData (flWData),
        .rAddr ({addrHi_r[1:0], addrLo_r}),
        .rData (flRd)
    );

    pnp_mem #(.DW(8), .AW(EE_AW)) u_nvdata (
        .clk   (clk),
        .we    (eeWe),
        .wAddr (eeWAddr),
        .wData (eeWData),
        .rAddr (addrLo_r[6:0]),
        .rData (eeRd)
    );

    // Fuses, lock bits, mode entry and latched fuse copies
    always_comb begin
        fuUpNxt  = fuUp_r;
        fuLoNxt  = fuLo_r;
        lockNxt  = lock_r;
        modeNxt  = mode_r;
        effUpNxt = effUp_r;
        effLoNxt = effLo_r;
        if (accept && wrFall && (cmd_r == CMD_WFUSE) && lock_r[0]) begin
            if (pins.pick1) begin
                fuUpNxt = dataLo_r | FU_UNUSED;
                if (pins.serial) begin
                    fuUpNxt[FU_SERIAL] = fuUp_r[FU_SERIAL];
                end
            end else begin
                fuLoNxt = dataLo_r;
            end
        end
        if (accept && wrFall && (cmd_r == CMD_WLOCK)) begin
            lockNxt = lock_r & dataLo_r[1:0];
        end
        // Locks release only once the flash walk has finished
        if ((state_r == S_DONE) && erasing_r) begin
            lockNxt = LOCK_RST;
        end
        if (!mode_r && hvRise && ({pins.pick1, pins.actHi, pins.actLo, pins.wrN} == 4'h0)) begin
            modeNxt = 1'b1;
        end else if (mode_r && hvFall) begin
            modeNxt = 1'b0;
        end
        if (pup_r || (modeNxt != mode_r)) begin
            effUpNxt = fuUp_r;
            effLoNxt = fuLo_r;
        end
        effUpNxt[FU_KEEP] = fuUp_r[FU_KEEP];
    end

    // Fuse and lock arrays are nonvolatile; reset restores shipped values
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            fuUp_r  <= FUSE_UP_RST;
            fuLo_r  <= FUSE_LO_RST;
            lock_r  <= LOCK_RST;
            mode_r  <= 1'b0;
            effUp_r <= FUSE_UP_RST;
            effLo_r <= FUSE_LO_RST;
            pup_r   <= 1'b1;
            trim_r  <= TRIM_1MHZ;
        end else begin
            fuUp_r  <= fuUpNxt;
            fuLo_r  <= fuLoNxt;
            lock_r  <= lockNxt;
            mode_r  <= modeNxt;
            effUp_r <= effUpNxt;
            effLo_r <= effLoNxt;
            pup_r   <= 1'b0;
            trim_r  <= trim_r;
        end
    end

    // Read data for the bus, chosen by the loaded command and byte picks
    always_comb begin
        dOeNxt  = mode_r && !pins.oeN;
        dOutNxt = BUS_IDLE;
        case (cmd_r)
            CMD_RFLASH: begin
                if (lock_r != 2'b00) begin
                    dOutNxt = pins.pick1 ? flRd[15:8] : flRd[7:0];
                end
            end
            CMD_REE: begin
                if (lock_r != 2'b00) begin
                    dOutNxt = eeRd;
                end
            end
            CMD_RFUSE: begin
                // Byte pick two is meaningful only here
                case ({pins.actHi, pins.pick1})
                    2'b00:   dOutNxt = fuLo_r;
                    2'b11:   dOutNxt = fuUp_r;
                    2'b01:   dOutNxt = {6'h3f, lock_r};
                    default: dOutNxt = BUS_IDLE;
                endcase
            end
            CMD_RSIG: begin
                // Identity and trims ignore the lock bits
                dOutNxt = pins.pick1 ? TRIM_VALS[addrLo_r[1:0]] : SIG_BYTES[addrLo_r[1:0]];
            end
            default: dOutNxt = BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            dOut_r  <= BUS_IDLE;
            dOe_r   <= 1'b0;
            ready_r <= 1'b1;
        end else begin
            dOut_r  <= dOutNxt;
            dOe_r   <= dOeNxt;
            ready_r <= (stateNxt == S_IDLE);
        end
    end

    assign dataOut      = dOut_r;
    assign dataOe       = dOe_r;
    assign readyFlag    = ready_r;
    assign progMode     = mode_r;
    assign fuseUpperEff = effUp_r;
    assign fuseLowerEff = effLo_r;
    assign oscTrim      = trim_r;

    default clocking @(posedge clk); endclocking
    default disable iff (!rstN);

    sequence s_eraseGo;
        accept && wrFall && (cmd_r == CMD_ERASE);
    endsequence
    sequence s_busy;
        !ready_r [*3];
    endsequence

    property p_bus_release;
        pins.oeN || !mode_r |=> !dOe_r;
    endproperty
    a_bus_release: assert property (p_bus_release) else $error("bus driven without output enable");

    property p_erase_busy;
        s_eraseGo |=> s_busy;
    endproperty
    a_erase_busy: assert property (p_erase_busy) else $error("ready high during erase");

    property p_busy_state;
        (state_r != S_IDLE) |-> !ready_r;
    endproperty
    a_busy_state: assert property (p_busy_state) else $error("ready high while busy");

    property p_locked_fuses;
        !lock_r[0] && (state_r != S_DONE) |=> $stable(fuUp_r) && $stable(fuLo_r);
    endproperty
    a_locked_fuses: assert property (p_locked_fuses) else $error("fuse changed while locked");

    property p_unused_high;
        fuUp_r[7:5] == 3'b111;
    endproperty
    a_unused_high: assert property (p_unused_high) else $error("unused fuse bits not one");

    property p_serial_keep;
        pins.serial |=> fuUp_r[FU_SERIAL] == $past(fuUp_r[FU_SERIAL]);
    endproperty
    a_serial_keep: assert property (p_serial_keep) else $error("serial fuse changed in serial mode");

    property p_load_only;
        !(accept && ldRise) |=> $stable(cmd_r) && $stable(addrLo_r) && $stable(addrHi_r);
    endproperty
    a_load_only: assert property (p_load_only) else $error("register changed without strobe");

    property p_cmd_load;
        accept && ldRise && ({pins.actHi, pins.actLo} == 2'b10) |=> cmd_r == $past(pins.data);
    endproperty
    a_cmd_load: assert property (p_cmd_load) else $error("command not loaded");

    property p_lock_release;
        (state_r == S_DONE) && erasing_r |=> lock_r == LOCK_RST;
    endproperty
    a_lock_release: assert property (p_lock_release) else $error("locks kept after erase");

    property p_latched;
        mode_r && $past(mode_r) |-> $stable(effLo_r);
    endproperty
    a_latched: assert property (p_latched) else $error("latched fuses moved in mode");
endmodule // pnp_port
`default_nettype wire

// ==== pnp_pkg.sv ====
// Constants, types and encodings for the parallel programming port
`default_nettype none
package pnp_pkg;
    // Flash geometry: 64 pages of 16 words, 10-bit word address
    localparam int         FL_AW    = 10;
    localparam logic [10:0] FL_WORDS = 11'h400;
    localparam logic [10:0] PG_WORDS = 11'h010;
    // Data memory geometry: 32 pages of 4 bytes, 7 live address bits
    localparam int         EE_AW    = 7;
    localparam logic [10:0] EE_PG    = 11'h004;
    localparam int         BUF_AW   = 4;
    // Upper configuration byte fields
    localparam int         FU_RSTIO  = 4;
    localparam int         FU_SERIAL = 3;
    localparam int         FU_KEEP   = 2;
    localparam int         FU_BODLVL = 1;
    localparam int         FU_BODON  = 0;
    localparam logic [7:0] FU_UNUSED = 8'he0;
    // Lower configuration byte fields
    localparam int         FL_PLL    = 7;
    localparam int         FL_OSCOPT = 6;
    localparam int         FL_SUT_LO = 4;
    localparam int         FL_CKS_LO = 0;
    // Reset values; a zero bit means programmed
    localparam logic [7:0] FUSE_UP_RST = 8'hf7;
    localparam logic [7:0] FUSE_LO_RST = 8'he1;
    localparam logic [1:0] LOCK_RST    = 2'b11;
    localparam logic [7:0] BUS_IDLE    = 8'hff;
    // Command bytes
    localparam logic [7:0] CMD_ERASE  = 8'h80;
    localparam logic [7:0] CMD_WFUSE  = 8'h40;
    localparam logic [7:0] CMD_WLOCK  = 8'h20;
    localparam logic [7:0] CMD_WFLASH = 8'h10;
    localparam logic [7:0] CMD_WEE    = 8'h11;
    localparam logic [7:0] CMD_RSIG   = 8'h08;
    localparam logic [7:0] CMD_RFUSE  = 8'h04;
    localparam logic [7:0] CMD_RFLASH = 8'h02;
    localparam logic [7:0] CMD_REE    = 8'h03;
    // Identification bytes, index 3 unused; values are arbitrary
    localparam logic [3:0][7:0] SIG_BYTES = {8'hff, 8'h42, 8'h3c, 8'h5a};
    // Oscillator trims for 8, 4, 2, 1 MHz; values are arbitrary
    localparam logic [3:0][7:0] TRIM_VALS = {8'h8c, 8'h88, 8'h84, 8'h80};
    localparam logic [7:0] TRIM_1MHZ = TRIM_VALS[0];

    typedef enum logic [1:0] {
        ACT_ADDR = 2'b00,
        ACT_DATA = 2'b01,
        ACT_CMD  = 2'b10,
        ACT_IDLE = 2'b11
    } pnp_act_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_WALK = 3'b010,
        S_DONE = 3'b100
    } pnp_state_t;

    // All programming pins, carried together through the synchroniser
    typedef struct packed {
        logic       ld;
        logic       actHi;
        logic       actLo;
        logic       pick1;
        logic       wrN;
        logic       oeN;
        logic       hv;
        logic       serial;
        logic [7:0] data;
    } pnp_pins_t;

    localparam pnp_pins_t PINS_RST = '{ld: 1'b0, actHi: 1'b0, actLo: 1'b0, pick1: 1'b0,
        wrN: 1'b1, oeN: 1'b1, hv: 1'b0, serial: 1'b0, data: 8'h00};
endpackage
`default_nettype wire

// ==== pnp_sync.sv ====
// Two-flop synchroniser for pin inputs, one chain per bit
`default_nettype none
module pnp_sync #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk,   // System clock
    input  wire logic         rstN,  // Synchronised reset, active low
    input  wire logic [W-1:0] d,     // Asynchronous inputs
    output logic      [W-1:0] q      // Synchronised outputs
);
    logic [W-1:0] meta_r;

    // First stage feeds only the second stage
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk or negedge rstN) begin
            if (!rstN) begin
                meta_r[i] <= INIT[i];
                q[i]      <= INIT[i];
            end else begin
                meta_r[i] <= d[i];
                q[i]      <= meta_r[i];
            end
        end
    end
endmodule // pnp_sync
`default_nettype wire

// ==== pnp_mem.sv ====
// Simple dual-port memory with registered read data
`default_nettype none
module pnp_mem #(
    parameter int DW = 8,
    parameter int AW = 7
) (
    input  wire logic          clk,    // System clock
    input  wire logic          we,     // Write enable
    input  wire logic [AW-1:0] wAddr,  // Write address
    input  wire logic [DW-1:0] wData,  // Write data
    input  wire logic [AW-1:0] rAddr,  // Read address
    output logic      [DW-1:0] rData   // Read data, one cycle late
);
    logic [DW-1:0] mem [2**AW];

    // No reset: contents are undefined until first written
    always_ff @(posedge clk) begin
        if (we) begin
            mem[wAddr] <= wData;
        end
        rData <= mem[rAddr];
    end
endmodule // pnp_mem
`default_nettype wire

// ==== pnp_prog_model.sv ====
// Behavioural model of the external parallel programmer
`default_nettype none
module pnp_prog_model (
    input  wire logic       clk,   // Bench clock, pins move on its falling edge
    input  wire logic [7:0] bus,   // Resolved data bus
    output logic            ld,    // Load strobe
    output logic      [1:0] act,   // Action selects, bit 1 doubles as pick two
    output logic            pick1, // Byte pick one
    output logic            wrN,   // Write strobe
    output logic            oeN,   // Output drive request
    output logic      [7:0] dout,  // Data the programmer drives
    output logic            drv    // High while the programmer drives the bus
);
    timeunit 1ns;
    timeprecision 1ns;
    // Entry pattern held low until the high voltage is applied
    initial begin
        {ld, act, pick1, wrN, oeN, dout, drv} = {5'h00, 1'b1, 8'h00, 1'b1};
    end
    // One 80 ns load pulse; selects held steady around it
    task automatic load(input logic [1:0] a, input logic p, input logic [7:0] d);
        @(negedge clk) {act, pick1, dout, drv, wrN} = {a, p, d, 2'b11};
        repeat (2) @(negedge clk);
        ld = 1'b1;
        repeat (4) @(negedge clk);
        ld = 1'b0;
        repeat (4) @(negedge clk);
        act = 2'b11; // Idle code, so stray pulses load nothing
    endtask
    // Negative write pulse performs the loaded command
    task automatic pulse_wr(input logic p);
        @(negedge clk) pick1 = p;
        repeat (2) @(negedge clk);
        wrN = 1'b0;
        repeat (4) @(negedge clk);
        wrN = 1'b1;
        repeat (4) @(negedge clk);
    endtask
    // Read with no load pulse; bus released so the device can drive
    task automatic rd(input logic p1, input logic p2, output logic [7:0] v);
        @(negedge clk) {oeN, pick1, act[1], drv} = {1'b0, p1, p2, 1'b0};
        repeat (6) @(negedge clk);
        v = bus;
        oeN = 1'b1;
        repeat (4) @(negedge clk); // Device lets go before we drive again
        drv = 1'b1;
    endtask
endmodule // pnp_prog_model
`default_nettype wire

// ==== pnp_port_tb.sv ====
// Self-checking bench for the parallel programming port
`default_nettype none
module pnp_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pnp_pkg::*;
    logic clk = 0, resetn = 0, progVoltage = 1, serial = 0, ld, pick1, wrN, oeN, drv, dataOe, readyFlag, progMode;
    logic [1:0] act;
    logic [7:0] dout, bus, dataOut, fuU, fuL, trim, v;
    int miscompares = 0, nTests = 0, cycles = 0;
    // Released bus shows the inverse of the last driven value, never a stale copy
    assign bus = dataOe ? dataOut : (drv ? dout : ~dout);
    always #10 clk = ~clk;
    pnp_port dut (.clk(clk), .resetn(resetn), .dataIn(bus), .dataOut(dataOut), .dataOe(dataOe),
        .loadStrobe(ld), .actionSelHi(act[1]), .actionSelLo(act[0]), .pageLatch(pick1),
        .programStrobeN(wrN), .outputDriveN(oeN), .progVoltage(progVoltage), .serialMode(serial),
        .readyFlag(readyFlag), .progMode(progMode), .fuseUpperEff(fuU), .fuseLowerEff(fuL), .oscTrim(trim));
    pnp_prog_model prog (.clk(clk), .bus(bus), .ld(ld), .act(act), .pick1(pick1), .wrN(wrN),
        .oeN(oeN), .dout(dout), .drv(drv));
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        nTests++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", nTests, miscompares);
        if (miscompares == 0 && nTests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Bounded wait for the ready flag
    task automatic wait_ready;
        repeat (1200) begin
            if (readyFlag === 1'b1) break;
            @(negedge clk);
        end
        check("ready after wait", 8'h01, {7'h0, readyFlag});
    endtask
    task automatic t_entry;
        repeat (8) @(negedge clk);
        check("progMode", 8'h01, {7'h0, progMode});
        check("fuseUpperEff", 8'hf7, fuU);
        check("fuseLowerEff", 8'he1, fuL);
        check("oscTrim", TRIM_VALS[0], trim);
        check("readyFlag", 8'h01, {7'h0, readyFlag});
        check("dataOe idle", 8'h00, {7'h0, dataOe});
    endtask
    task automatic t_sig;
        prog.load(2'b10, 1'b0, CMD_RSIG);
        for (int i = 0; i < 3; i++) begin
            prog.load(2'b00, 1'b0, 8'(i));
            prog.rd(1'b0, 1'b0, v);
            check("signature", SIG_BYTES[i], v);
        end
        prog.rd(1'b1, 1'b0, v);
        check("trim 4 MHz", TRIM_VALS[2], v);
    endtask
    task automatic t_fuse;
        prog.load(2'b10, 1'b0, CMD_RFUSE);
        prog.rd(1'b1, 1'b1, v);
        check("upper fuse", 8'hf7, v);
        prog.load(2'b10, 1'b0, CMD_WFUSE);
        prog.load(2'b01, 1'b0, 8'h24);
        prog.pulse_wr(1'b0);
        wait_ready();
        prog.load(2'b10, 1'b0, CMD_RFUSE);
        prog.rd(1'b0, 1'b0, v);
        check("lower fuse", 8'h24, v);
        check("fuseLowerEff held", 8'he1, fuL);
        // Serial side active: the serial-load bit must not move
        serial = 1'b1;
        prog.load(2'b10, 1'b0, CMD_WFUSE);
        prog.load(2'b01, 1'b0, 8'hff);
        prog.pulse_wr(1'b1);
        wait_ready();
        prog.load(2'b10, 1'b0, CMD_RFUSE);
        prog.rd(1'b1, 1'b1, v);
        check("upper fuse serial kept", 8'hf7, v);
        // Same write with the serial side idle does land
        serial = 1'b0;
        prog.load(2'b10, 1'b0, CMD_WFUSE);
        prog.pulse_wr(1'b1);
        wait_ready();
        prog.load(2'b10, 1'b0, CMD_RFUSE);
        prog.rd(1'b1, 1'b1, v);
        check("upper fuse written", 8'hff, v);
    endtask
    task automatic t_erase;
        prog.load(2'b10, 1'b0, CMD_ERASE);
        prog.pulse_wr(1'b0);
        check("busy", 8'h00, {7'h0, readyFlag});
        wait_ready();
        check("ready", 8'h01, {7'h0, readyFlag});
        prog.load(2'b10, 1'b0, CMD_RFUSE);
        prog.rd(1'b0, 1'b0, v);
        check("fuse after erase", 8'h24, v);
        // Address 2 is still loaded from the signature reads
        prog.load(2'b10, 1'b0, CMD_RFLASH);
        prog.rd(1'b0, 1'b0, v);
        check("flash erased", 8'hff, v);
        prog.load(2'b10, 1'b0, CMD_WFLASH);
        prog.load(2'b01, 1'b0, 8'ha5);
        prog.load(2'b01, 1'b1, 8'hc3);
        prog.pulse_wr(1'b0);
        wait_ready();
        prog.load(2'b10, 1'b0, CMD_RFLASH);
        prog.rd(1'b1, 1'b0, v);
        check("flash high byte", 8'hc3, v);
        prog.rd(1'b0, 1'b0, v);
        check("flash low byte", 8'ha5, v);
        progVoltage = 1'b0;
        repeat (8) @(negedge clk);
        check("progMode off", 8'h00, {7'h0, progMode});
        check("fuseLowerEff", 8'h24, fuL);
        check("fuseUpperEff", 8'hff, fuU);
    endtask
    // Cuts a hang short; the full run needs about 1500 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            miscompares++;
            end_of_test();
        end
    end
    initial begin
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        t_entry();
        t_sig();
        t_fuse();
        t_erase();
        end_of_test();
    end
endmodule // pnp_port_tb
`default_nettype wire
